// file: logic/amt_pkg.sv
// Purpose: Shared constants of the automute threshold and delay register bank
// Assumes: 50 MHz pclk, registers reached over APB with 32-bit data
// Notes: Register indices are kept; the byte address is four times the index
package amt_pkg;
	// Register indices and the word-address width they are compared against
	localparam int AMT_IDX_W = 10;
	localparam logic [9:0] AMT_IDX_SILENCE = 10'h014;
	localparam logic [9:0] AMT_IDX_OUT_OFS = 10'h015;
	localparam logic [9:0] AMT_IDX_STATUS = 10'h018;
	// Reset values
	localparam logic [7:0] AMT_SILENCE_RST = 8'h00;
	localparam logic [7:0] AMT_OUT_OFS_RST = 8'h00;
	// Field positions: every field is one nibble
	localparam int AMT_LO_LSB = 0;
	localparam int AMT_HI_LSB = 4;
	localparam int AMT_NIB_W = 4;
	// Shared silence delay decode
	localparam logic [3:0] AMT_DLY_FINE_MAX = 4'h4;
	localparam logic [6:0] AMT_DLY_COARSE_MS = 7'h0a;
	localparam logic [3:0] AMT_DLY_COARSE_BASE = 4'h4;
	// Threshold decode
	localparam logic [4:0] AMT_THR_MIN_BIT = 5'h01;
	localparam logic [3:0] AMT_OFS_NEG_BASE = 4'h8;
	// Back-end reset period decode
	localparam logic [3:0] AMT_BE_SAT_CODE = 4'ha;
	localparam int AMT_BE_SAT_MS = 10;
	localparam int AMT_BE_SHORT_US = 100;
	// Timing
	localparam int AMT_CLK_HZ = 50000000;
	localparam int AMT_MS_CYC = AMT_CLK_HZ / 1000;
	localparam int AMT_BE_SHORT_CYC = (AMT_CLK_HZ / 1000000) * AMT_BE_SHORT_US;
	// Status register layout
	localparam int AMT_ST_OUT_LSB = 8;
	localparam int AMT_ST_BE_BIT = 16;
endpackage

// file: logic/amt_tick_div.sv
// Purpose: Free-running divider giving a one-cycle pulse per period
// Assumes: Single pclk domain
// Notes: The pulse comes from a flip-flop
module amt_tick_div #(
	parameter int CYC = 50000
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Period pulse
	output logic tick_ff
);
	localparam int CW = $clog2(CYC);
	logic [CW-1:0] cnt_ff;

	// Count down and pulse on wrap
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
			tick_ff <= 1'b0;
		end else if (cnt_ff == '0) begin
			cnt_ff <= CW'(CYC - 1);
			tick_ff <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff - 1'b1;
			tick_ff <= 1'b0;
		end
	end
endmodule // amt_tick_div

// file: logic/amt_chan_det.sv
// Purpose: Silence detector for one channel stream
// Assumes: Samples are two's complement, tick_ms is a one-cycle pulse per ms
// Notes: Mute engages after more than dly_ms whole ms of unbroken silence
module amt_chan_det #(
	parameter int SW = 24
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick_ms,
	// Sample stream
	input wire logic smp_vld,
	input wire logic [SW-1:0] smp_data,
	// Settings
	input wire logic [4:0] thr_bit,
	input wire logic [6:0] dly_ms,
	// Result
	output logic mute_ff
);
	logic [SW-1:0] mag;
	logic quiet;
	logic [4:0] shamt;
	logic silent_ff;
	logic [7:0] cnt_ff;

	// Magnitude; the most negative value maps to 2^(SW-1) correctly
	assign mag = smp_data[SW-1] ? (~smp_data + 1'b1) : smp_data;
	// Threshold bits count from 1 at the LSB: below bit k means a magnitude under 2^(k-1)
	assign shamt = (thr_bit == 5'h00) ? 5'h00 : thr_bit - 5'h01;
	assign quiet = ((mag >> shamt) == '0);

	// Track whether the latest sample was below threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			silent_ff <= 1'b0;
		end else if (smp_vld) begin
			silent_ff <= quiet;
		end
	end

	// Count whole ms ticks of silence, saturating
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_ff <= '0;
		end else if (smp_vld && !quiet) begin
			cnt_ff <= '0;
		end else if (silent_ff && tick_ms && cnt_ff != 8'hff) begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	// Engage after the delay, release on the first loud sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mute_ff <= 1'b0;
		end else if (smp_vld && !quiet) begin
			mute_ff <= 1'b0;
		end else if (silent_ff && cnt_ff > {1'b0, dly_ms}) begin
			mute_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_loud;
		smp_vld && !quiet;
	endsequence
	property p_release;
		s_loud |=> !mute_ff;
	endproperty
	a_release: assert property (p_release) else $error("Mute held after loud sample");
	property p_engage;
		$rose(mute_ff) |-> $past(silent_ff) && ($past(cnt_ff) > {1'b0, $past(dly_ms)});
	endproperty
	a_engage: assert property (p_engage) else $error("Mute engaged before delay");
endmodule // amt_chan_det

// file: logic/amt_regs_top.sv
// Purpose: Automute threshold and delay register bank with silence detection
// Assumes: APB3 slave, one wait state on every access, 50 MHz pclk
// Notes: Eight channels, input and output streams time-multiplexed by channel
//
// Our own choice: the APB slave port.
module amt_regs_top #(
	parameter int SW = 24,
	parameter int NCH = 8,
	parameter int MS_CYC = amt_pkg::AMT_MS_CYC,
	parameter int BE_SHORT_CYC = amt_pkg::AMT_BE_SHORT_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_ff,
	output logic pready_ff,
	output logic pslverr_ff,
	// Input-side samples
	input wire logic in_vld,
	input wire logic [2:0] in_chan,
	input wire logic [SW-1:0] in_data,
	// Output-side samples
	input wire logic out_vld,
	input wire logic [2:0] out_chan,
	input wire logic [SW-1:0] out_data,
	// Back-end reset
	input wire logic be_reset_req,
	output logic be_reset_ff,
	// Mute flags
	output logic [NCH-1:0] in_mute_ff,
	output logic [NCH-1:0] out_mute_ff
);
	import amt_pkg::*;

	localparam int BE_W = $clog2(AMT_BE_SAT_MS * MS_CYC + 1);

	logic [7:0] silence_ff;
	logic [7:0] out_ofs_ff;
	logic [3:0] dly_code;
	logic [3:0] thr_code;
	logic [3:0] ofs_code;
	logic [3:0] be_code;
	logic [6:0] dly_ms;
	logic [4:0] thr_in;
	logic [4:0] thr_out;
	logic signed [6:0] thr_sum;
	logic [3:0] be_ms;
	logic [BE_W-1:0] be_len;
	logic [BE_W-1:0] be_cnt_ff;
	logic [3:0] be_code_ff;
	logic [BE_W:0] hlp_run_ff;
	logic tick_ms;
	logic [9:0] idx;
	logic hit_silence;
	logic hit_out_ofs;
	logic hit_status;
	logic mapped;
	logic acc;
	logic wr_take;
	logic [31:0] rd_mux;
	logic [NCH-1:0] in_mute;
	logic [NCH-1:0] out_mute;

	// Field split
	assign dly_code = silence_ff[AMT_LO_LSB +: AMT_NIB_W];
	assign thr_code = silence_ff[AMT_HI_LSB +: AMT_NIB_W];
	assign ofs_code = out_ofs_ff[AMT_HI_LSB +: AMT_NIB_W];
	assign be_code = out_ofs_ff[AMT_LO_LSB +: AMT_NIB_W];

	// Shared silence delay in whole ms
	always_comb begin
		if (dly_code <= AMT_DLY_FINE_MAX) begin
			dly_ms = {3'h0, dly_code} + 7'h01;
		end else begin
			dly_ms = 7'({3'h0, dly_code - AMT_DLY_COARSE_BASE} * AMT_DLY_COARSE_MS);
		end
	end

	// Input threshold bit position
	always_comb begin
		if ({1'b0, thr_code} < AMT_THR_MIN_BIT + 5'h01) begin
			thr_in = AMT_THR_MIN_BIT;
		end else begin
			thr_in = {1'b0, thr_code};
		end
	end

	// Output threshold relative to the input one, floored at bit 0
	always_comb begin
		if (ofs_code == 4'h0 || ofs_code == AMT_OFS_NEG_BASE) begin
			thr_sum = 7'(thr_in);
		end else if (ofs_code < AMT_OFS_NEG_BASE) begin
			thr_sum = 7'(thr_in) + 7'(ofs_code);
		end else begin
			thr_sum = 7'(thr_in) - 7'(ofs_code - AMT_OFS_NEG_BASE);
		end
		thr_out = (thr_sum < 0) ? 5'h00 : thr_sum[4:0];
	end

	// Back-end reset period length in cycles
	always_comb begin
		be_ms = (be_code >= AMT_BE_SAT_CODE) ? 4'(AMT_BE_SAT_MS) : be_code;
		if (be_code == 4'h0) begin
			be_len = BE_W'(BE_SHORT_CYC);
		end else begin
			be_len = BE_W'(int'(be_ms) * MS_CYC);
		end
	end

	// Millisecond timebase for the silence counters
	amt_tick_div #(
		.CYC(MS_CYC)
	) u_ms (
		.pclk(pclk),
		.presetn(presetn),
		.tick_ff(tick_ms)
	);

	// One input-side and one output-side detector per channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			amt_chan_det #(
				.SW(SW)
			) u_in (
				.pclk(pclk),
				.presetn(presetn),
				.tick_ms(tick_ms),
				.smp_vld(in_vld && in_chan == 3'(g)),
				.smp_data(in_data),
				.thr_bit(thr_in),
				.dly_ms(dly_ms),
				.mute_ff(in_mute[g])
			);
			amt_chan_det #(
				.SW(SW)
			) u_out (
				.pclk(pclk),
				.presetn(presetn),
				.tick_ms(tick_ms),
				.smp_vld(out_vld && out_chan == 3'(g)),
				.smp_data(out_data),
				.thr_bit(thr_out),
				.dly_ms(dly_ms),
				.mute_ff(out_mute[g])
			);
		end
	endgenerate

	// Detector flags drive the ports directly from their flops
	assign in_mute_ff = in_mute;
	assign out_mute_ff = out_mute;

	// Back-end reset timer; a new request restarts the period
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			be_reset_ff <= 1'b0;
			be_cnt_ff <= '0;
			be_code_ff <= 4'h0;
		end else if (be_reset_req) begin
			be_reset_ff <= 1'b1;
			be_cnt_ff <= be_len - 1'b1;
			be_code_ff <= be_code;
		end else if (be_reset_ff) begin
			if (be_cnt_ff == '0) begin
				be_reset_ff <= 1'b0;
			end else begin
				be_cnt_ff <= be_cnt_ff - 1'b1;
			end
		end
	end

	// Address decode
	assign idx = paddr[11:2];
	assign hit_silence = (idx == AMT_IDX_SILENCE);
	assign hit_out_ofs = (idx == AMT_IDX_OUT_OFS);
	assign hit_status = (idx == AMT_IDX_STATUS);
	assign mapped = hit_silence || hit_out_ofs || hit_status;
	assign acc = psel && penable;
	assign wr_take = acc && pready_ff && pwrite;

	// Read mux, upper bits read as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_silence) begin
			rd_mux[7:0] = silence_ff;
		end else if (hit_out_ofs) begin
			rd_mux[7:0] = out_ofs_ff;
		end else if (hit_status) begin
			rd_mux[NCH-1:0] = in_mute;
			rd_mux[AMT_ST_OUT_LSB +: NCH] = out_mute;
			rd_mux[AMT_ST_BE_BIT] = be_reset_ff;
		end
	end

	// One wait state: ready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else if (acc && !pready_ff) begin
			pready_ff <= 1'b1;
			pslverr_ff <= !mapped;
			prdata_ff <= pwrite ? 32'h0000_0000 : rd_mux;
		end else begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end
	end

	// Silence threshold and delay register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			silence_ff <= AMT_SILENCE_RST;
		end else if (wr_take && hit_silence) begin
			silence_ff <= pwdata[7:0];
		end
	end

	// Output offset and back-end period register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ofs_ff <= AMT_OUT_OFS_RST;
		end else if (wr_take && hit_out_ofs) begin
			out_ofs_ff <= pwdata[7:0];
		end
	end

	// Cycle count of the current back-end reset period, for checking
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hlp_run_ff <= '0;
		end else if (be_reset_req) begin
			hlp_run_ff <= '0;
		end else if (be_reset_ff) begin
			hlp_run_ff <= hlp_run_ff + 1'b1;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_dly_fine;
		dly_code <= 4'h4 |-> dly_ms == 7'(dly_code) + 7'h01;
	endproperty
	a_dly_fine: assert property (p_dly_fine) else $error("Fine delay decode wrong");

	property p_dly_coarse;
		dly_code > 4'h4 |-> dly_ms == 7'(7'(dly_code) - 7'h04) * 7'h0a;
	endproperty
	a_dly_coarse: assert property (p_dly_coarse) else $error("Coarse delay decode wrong");

	property p_thr_low;
		thr_code < 4'h2 |-> thr_in == 5'h01;
	endproperty
	a_thr_low: assert property (p_thr_low) else $error("Lowest threshold wrong");

	property p_thr_high;
		thr_code >= 4'h2 |-> thr_in == 5'(thr_code);
	endproperty
	a_thr_high: assert property (p_thr_high) else $error("Input threshold wrong");

	property p_ofs_eq;
		(ofs_code == 4'h0 || ofs_code == 4'h8) |-> thr_out == thr_in;
	endproperty
	a_ofs_eq: assert property (p_ofs_eq) else $error("Equal offset wrong");

	property p_ofs_up;
		(ofs_code != 4'h0 && ofs_code < 4'h8) |-> thr_out == thr_in + 5'(ofs_code);
	endproperty
	a_ofs_up: assert property (p_ofs_up) else $error("Upward offset wrong");

	property p_ofs_dn;
		(ofs_code > 4'h8 && 5'(ofs_code) - 5'h08 <= thr_in)
			|-> thr_out == thr_in - (5'(ofs_code) - 5'h08);
	endproperty
	a_ofs_dn: assert property (p_ofs_dn) else $error("Downward offset wrong");

	sequence s_be_end;
		$fell(be_reset_ff) && !$past(be_reset_req);
	endsequence

	property p_be_short;
		(s_be_end and (be_code_ff == 4'h0)) |-> $past(hlp_run_ff) + 1 < (BE_W+1)'(MS_CYC);
	endproperty
	a_be_short: assert property (p_be_short) else $error("Short period not below 1 ms");

	property p_be_ms;
		(s_be_end and (be_code_ff != 4'h0 && be_code_ff < 4'ha))
			|-> $past(hlp_run_ff) + 1 == (BE_W+1)'(int'(be_code_ff) * MS_CYC);
	endproperty
	a_be_ms: assert property (p_be_ms) else $error("Period not code ms");

	property p_be_sat;
		(s_be_end and (be_code_ff >= 4'ha))
			|-> $past(hlp_run_ff) + 1 == (BE_W+1)'(10 * MS_CYC);
	endproperty
	a_be_sat: assert property (p_be_sat) else $error("Period not saturated at 10 ms");

	property p_apb_wait;
		psel && penable && !pready_ff |=> pready_ff;
	endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("APB answer missing");

	property p_ready_pulse;
		pready_ff |=> !pready_ff;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("Ready held too long");

	// Unmapped indices answer with an error in the same ready cycle
	property p_apb_err;
		psel && penable && !pready_ff && !mapped |=> pslverr_ff;
	endproperty
	a_apb_err: assert property (p_apb_err) else $error("Unmapped access without error");

	// Registers only change on an accepted write to their own index
	property p_no_stray_wr;
		!(wr_take && (hit_silence || hit_out_ofs)) |=> $stable(silence_ff) && $stable(out_ofs_ff);
	endproperty
	a_no_stray_wr: assert property (p_no_stray_wr) else $error("Register changed without write");

	// Output threshold pushed below the bottom clamps at the lowest setting
	property p_ofs_floor;
		(ofs_code > 4'h8 && 5'(ofs_code) - 5'h08 > thr_in) |-> thr_out == 5'h00;
	endproperty
	a_ofs_floor: assert property (p_ofs_floor) else $error("Output threshold floor wrong");

	// A request starts or restarts the back-end period at the next edge
	property p_be_start;
		be_reset_req |=> be_reset_ff && be_code_ff == $past(be_code);
	endproperty
	a_be_start: assert property (p_be_start) else $error("Back-end period not started");
endmodule // amt_regs_top

// file: verif/amt_regs_top_tb_top.sv
// Purpose: Self-checking bench for the automute threshold and delay register bank
// Assumes: APB slave with one wait state, millisecond count shortened to MS cycles
// Notes: Registers, shared delay, both thresholds and back-end reset period are swept
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin \
	err_total++; $display("CHECK FAILED %0t %s", $time, m); end end

module amt_regs_top_tb_top import amt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Shortened timebase keeps the run small
	localparam int MS = 20;
	localparam int BES = 5;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic in_vld = 1'b0;
	logic out_vld = 1'b0;
	logic be_reset_req = 1'b0;
	logic [2:0] in_chan = 3'h0;
	logic [2:0] out_chan = 3'h0;
	logic [23:0] in_data = 24'h0;
	logic [23:0] out_data = 24'h0;
	logic be_reset_ff;
	logic [7:0] in_mute_ff;
	logic [7:0] out_mute_ff;
	int err_total = 0;
	int check_count = 0;
	int n;
	int lo;
	logic [31:0] rd;
	logic er;

	amt_regs_top #(.SW(24), .NCH(8), .MS_CYC(MS), .BE_SHORT_CYC(BES)) dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
		.pslverr_ff(pslverr_ff), .in_vld(in_vld), .in_chan(in_chan), .in_data(in_data),
		.out_vld(out_vld), .out_chan(out_chan), .out_data(out_data),
		.be_reset_req(be_reset_req), .be_reset_ff(be_reset_ff),
		.in_mute_ff(in_mute_ff), .out_mute_ff(out_mute_ff)
	);

	// Clock, 20 ns period
	initial begin
		forever #10 pclk = ~pclk;
	end

	// Verdict and end of run
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready_ff !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		rd = prdata_ff;
		er = pslverr_ff;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(k < 20, 1'b1, "apb no answer")
	endtask

	// Read and compare data and error flag
	task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e, "read data")
		`CHK(er, ee, "read error")
	endtask

	// One sample on the input or output stream
	task automatic smp(input logic o, input logic [2:0] ch, input logic [23:0] v);
		@(posedge pclk);
		in_vld <= !o;
		out_vld <= o;
		in_chan <= ch;
		out_chan <= ch;
		in_data <= v;
		out_data <= v;
		@(posedge pclk);
		in_vld <= 1'b0;
		out_vld <= 1'b0;
	endtask

	function automatic logic mute(input logic o, input logic [2:0] ch);
		return o ? out_mute_ff[ch] : in_mute_ff[ch];
	endfunction

	// Pulse the back-end request, again after gap cycles if gap is set, and count the period
	task automatic be_run(input int gap);
		@(posedge pclk);
		be_reset_req <= 1'b1;
		@(posedge pclk);
		be_reset_req <= 1'b0;
		if (gap > 0) begin
			repeat (gap) @(posedge pclk);
			be_reset_req <= 1'b1;
			@(posedge pclk);
			be_reset_req <= 1'b0;
		end
		#1;
		n = 0;
		while (be_reset_ff === 1'b1 && n < 400) begin
			n++;
			@(posedge pclk);
			#1;
		end
	endtask

	// Loud value first clears any old mute; quiet value must then mute after 1 ms
	task automatic probe(input logic o, input logic [2:0] ch, input logic [23:0] q,
		input logic [23:0] l);
		smp(o, ch, l);
		smp(o, ch, q);
		repeat (3 * MS + 4) @(posedge pclk);
		#1;
		`CHK(mute(o, ch), 1'b1, "quiet sample not muted")
		smp(o, ch, l);
		@(posedge pclk);
		#1;
		`CHK(mute(o, ch), 1'b0, "loud sample kept mute")
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rchk(12'h050, 32'h0, 1'b0);
		rchk(12'h054, 32'h0, 1'b0);
		rchk(12'h058, 32'h0, 1'b1);
		apb(1'b1, 12'h050, 32'hffff_ffa5);
		rchk(12'h050, 32'h0000_00a5, 1'b0);
		apb(1'b1, 12'h054, 32'h0000_005c);
		rchk(12'h054, 32'h0000_005c, 1'b0);
		rchk(12'h060, 32'h0, 1'b0);
		apb(1'b1, 12'h058, 32'h0000_00ff);
		`CHK(er, 1'b1, "unmapped write error")
		apb(1'b1, 12'h060, 32'h0000_00ff);
		`CHK(er, 1'b0, "status write error")
		rchk(12'h060, 32'h0, 1'b0);
		rchk(12'h050, 32'h0000_00a5, 1'b0);
		rchk(12'h054, 32'h0000_005c, 1'b0);
		$display("test registers done");
		// Shared delay, time from first quiet sample to mute
		for (int d = 0; d < 16; d++) begin
			apb(1'b1, 12'h050, {28'h0, d[3:0]});
			smp(1'b0, 3'h0, 24'h2);
			smp(1'b0, 3'h0, 24'h0);
			n = 0;
			while (in_mute_ff[0] !== 1'b1 && n < 3000) begin
				@(posedge pclk);
				n++;
			end
			lo = (d < 5) ? (d + 1) * MS : (d - 4) * 10 * MS;
			`CHK(n >= lo + 3 && n <= lo + MS + 2, 1'b1, "mute delay")
			if (d == 0)
				rchk(12'h060, 32'h1, 1'b0);
		end
		$display("test delay done");
		// Input threshold codes
		for (int t = 0; t < 16; t++) begin
			apb(1'b1, 12'h050, {24'h0, t[3:0], 4'h0});
			probe(1'b0, t[2:0], (t < 2) ? 24'h0 : (24'h1 << (t - 1)) - 24'h1,
				(t < 2) ? 24'h1 : 24'h1 << (t - 1));
		end
		// Output offset codes around input threshold bit 8
		apb(1'b1, 12'h050, 32'h0000_0080);
		for (int o = 0; o < 16; o++) begin
			lo = (o < 8) ? 8 + o : 16 - o;
			apb(1'b1, 12'h054, {24'h0, o[3:0], 4'h0});
			probe(1'b1, o[2:0], (24'h1 << (lo - 1)) - 24'h1, 24'h1 << (lo - 1));
		end
		$display("test thresholds done");
		// Back-end reset period for every code
		for (int c = 0; c < 16; c++) begin
			apb(1'b1, 12'h054, {28'h0, c[3:0]});
			be_run(0);
			lo = (c == 0) ? BES : (c < 10) ? c * MS : AMT_BE_SAT_MS * MS;
			`CHK(n, lo, "back-end period")
		end
		// A second request in mid-period restarts the full period
		be_run(50);
		`CHK(n, AMT_BE_SAT_MS * MS, "retriggered period")
		$display("test back-end reset done");
		results;
	end

	// Watchdog against a hang
	initial begin
		repeat (60000) @(posedge pclk);
		err_total++;
		results;
	end
endmodule // amt_regs_top_tb_top
